// [nv_seq_pkg.sv]
// Constants, types and the summary of operation for the save/restore sequencer
// Summary of operation
// R1 - Skip power-loss or pin save when nothing written
// R2 - Ignore host cycles during transfers and low supply
// R3 - Keep SRAM enabled 25 ns after save triggers
// R4 - Save/restore lock serial IO; restore 600us, save 8ms
// R5 - Start acting on software command within 500us
// R6 - Reach sleep within 8 ms of instruction
// R7 - Awake and accepting commands within 20 ms
// R8 - Enter standby within 100 us of deselect
// R9 - Resume operation within 5 us after busy release
// R10 - Host waits out transfers instead of relying on ignore
package nv_seq_pkg;
  localparam int CLK_MHZ = 25;
  localparam int CLK_NS = 40;
  // Times as printed
  localparam int T_DELAY_NS = 25;
  localparam int T_FA_MS = 20;
  localparam int T_STORE_MS = 8;
  localparam int T_RECALL_US = 600;
  localparam int T_SS_US = 500;
  localparam int T_SLEEP_MS = 8;
  localparam int T_WAKE_MS = 20;
  localparam int T_SB_US = 100;
  localparam int T_LZHSB_US = 5;
  // Least time rounds up, longest rounds down, never below one cycle
  localparam int CYC_DELAY = (T_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CYC_FA = T_FA_MS * 1000 * CLK_MHZ;
  localparam int CYC_STORE = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int CYC_RECALL = T_RECALL_US * CLK_MHZ;
  localparam int CYC_SS = T_SS_US * CLK_MHZ;
  localparam int CYC_SLEEP = T_SLEEP_MS * 1000 * CLK_MHZ;
  localparam int CYC_WAKE = T_WAKE_MS * 1000 * CLK_MHZ;
  localparam int CYC_SB = T_SB_US * CLK_MHZ;
  localparam int CYC_LZHSB = T_LZHSB_US * CLK_MHZ;
  localparam int CNT_W = 20;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_SAVE, CMD_RESTORE, CMD_AUTO_EN, CMD_AUTO_DIS, CMD_SLEEP
  } sw_cmd_t;
  typedef struct packed {
    logic valid;
    sw_cmd_t cmd;
  } sw_req_t;
  typedef struct packed {
    logic access_ok;
    logic sram_en;
    logic saving;
    logic restoring;
    logic sleeping;
    logic standby;
  } seq_status_t;
endpackage

// [nv_delay_timer.sv]
// Down counter that reports when a loaded interval has elapsed
module nv_delay_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] count,
  // Status
  output logic done
);
  logic [W-1:0] remain;
  logic [W-1:0] next_remain;
  logic next_done;

  always_comb
  begin
    next_remain = remain;
    next_done = 1'b0;
    if (load)
    begin
      next_remain = count;
    end
    else if (remain != '0)
    begin
      next_remain = remain - 1'b1;
      next_done = (remain == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= '0;
      done <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      done <= next_done;
    end
  end
endmodule

// [nv_store_recall_sequencer.sv]
// Save and restore sequencer between SRAM and nonvolatile shadow
module nv_store_recall_sequencer
  import nv_seq_pkg::*;
#(
  parameter int FA_CYC = CYC_FA,
  parameter int STORE_CYC = CYC_STORE,
  parameter int RECALL_CYC = CYC_RECALL,
  parameter int SS_CYC = CYC_SS,
  parameter int SLEEP_CYC = CYC_SLEEP,
  parameter int WAKE_CYC = CYC_WAKE,
  parameter int SB_CYC = CYC_SB
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Supply and pin events
  input wire logic vcc_ok,
  input wire logic cs_n,
  input wire logic wake_req,
  // Bidirectional store-busy pin, active low
  input wire logic store_busy_pin_in,
  output logic store_busy_pin_out,
  output logic store_busy_pin_oe,
  // Software command and SRAM write notice
  input wire nv_seq_pkg::sw_req_t sw_req,
  input wire logic sram_write,
  // Shadow transfer strobes and status
  output logic xfer_save,
  output logic xfer_restore,
  output nv_seq_pkg::seq_status_t status
);
  import nv_seq_pkg::*;
  typedef enum logic [3:0] {
    ST_POWERUP, ST_RESTORE, ST_IDLE, ST_CMD_WAIT, ST_DELAY, ST_SAVE,
    ST_SLEEP_ENTER, ST_SLEEP, ST_WAKE, ST_RESUME
  } state_t;
  // Synchronisers for pin inputs
  logic [1:0] vcc_sync, cs_sync, busy_sync, wake_sync, rst_sync;
  logic rst_int_n;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_int_n = rst_sync[1];

  always_ff @(posedge clk_sys or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      vcc_sync <= 2'b00;
      cs_sync <= 2'b11;
      busy_sync <= 2'b11;
      wake_sync <= 2'b00;
    end
    else
    begin
      vcc_sync <= {vcc_sync[0], vcc_ok};
      cs_sync <= {cs_sync[0], cs_n};
      busy_sync <= {busy_sync[0], store_busy_pin_in};
      wake_sync <= {wake_sync[0], wake_req};
    end
  end

  logic vcc_s, cs_s, busy_s, wake_s;
  assign vcc_s = vcc_sync[1];
  assign cs_s = cs_sync[1];
  assign busy_s = busy_sync[1];
  assign wake_s = wake_sync[1];
  state_t state, next_state;
  sw_cmd_t pend, next_pend;
  logic dirty, next_dirty;
  logic auto_en, next_auto_en;
  logic do_save, next_do_save;
  logic vcc_prev, next_vcc_prev;
  logic busy_prev, next_busy_prev;
  logic [CNT_W-1:0] sb_cnt, next_sb_cnt;
  logic standby, next_standby;
  logic next_xfer_save, next_xfer_restore;
  logic next_pin_out, next_pin_oe;
  seq_status_t next_status;
  logic t_load, t_done;
  logic [CNT_W-1:0] t_count;

  nv_delay_timer #(.W(CNT_W)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_int_n),
    .load(t_load),
    .count(t_count),
    .done(t_done)
  );

  always_comb
  begin
    next_state = state;
    next_pend = pend;
    next_auto_en = auto_en;
    next_do_save = do_save;
    next_vcc_prev = vcc_s;
    next_busy_prev = busy_s;
    next_xfer_save = 1'b0;
    next_xfer_restore = 1'b0;
    next_pin_out = 1'b1;
    next_pin_oe = 1'b0;
    t_load = 1'b0;
    t_count = '0;
    // Set wins over clear, but a write in the save cycle is dropped as access_ok is low
    next_dirty = dirty;
    unique case (state)
      ST_POWERUP:
      begin
        if (vcc_s)
        begin
          next_state = ST_RESTORE;
          next_xfer_restore = 1'b1;
          t_load = 1'b1;
          t_count = CNT_W'(FA_CYC); // R2
        end
      end
      ST_RESTORE:
      begin
        if (!vcc_s)
          next_state = ST_POWERUP; // R2
        else if (t_done)
        begin
          next_state = ST_IDLE;
          next_dirty = 1'b0;
        end
      end
      ST_IDLE:
      begin
        if (vcc_prev && !vcc_s)
        begin
          // Power loss: only save when armed and something was written
          next_do_save = auto_en && dirty; // R1
          next_state = ST_DELAY;
          t_load = 1'b1;
          t_count = CNT_W'(CYC_DELAY); // R3
        end
        else if (busy_prev && !busy_s)
        begin
          next_do_save = dirty; // R1
          next_state = ST_DELAY;
          t_load = 1'b1;
          t_count = CNT_W'(CYC_DELAY); // R3
        end
        else if (sw_req.valid && sw_req.cmd != CMD_NONE && cs_s)
        begin
          next_pend = sw_req.cmd;
          next_state = ST_CMD_WAIT;
          t_load = 1'b1;
          t_count = CNT_W'(SS_CYC); // R5
        end
      end
      ST_CMD_WAIT:
      begin
        // Acts on the command early; the interval is an upper bound
        next_state = ST_DELAY; // R5
        t_load = 1'b1;
        t_count = CNT_W'(CYC_DELAY); // R3
        next_do_save = (pend == CMD_SAVE);
        if (pend == CMD_AUTO_EN)
          next_auto_en = 1'b1;
        if (pend == CMD_AUTO_DIS)
          next_auto_en = 1'b0;
        if (pend == CMD_SLEEP)
        begin
          next_state = ST_SLEEP_ENTER;
          t_count = CNT_W'(SLEEP_CYC); // R6
        end
      end
      ST_DELAY:
      begin
        if (t_done)
        begin
          t_load = 1'b1;
          if (do_save)
          begin
            next_state = ST_SAVE;
            next_xfer_save = 1'b1;
            t_count = CNT_W'(STORE_CYC); // R4
          end
          else if (pend == CMD_RESTORE)
          begin
            next_state = ST_RESTORE;
            next_xfer_restore = 1'b1;
            t_count = CNT_W'(RECALL_CYC); // R4
          end
          else
          begin
            next_state = ST_RESUME;
            t_count = CNT_W'(CYC_LZHSB); // R9
          end
          next_pend = CMD_NONE;
        end
      end
      ST_SAVE:
      begin
        next_pin_out = 1'b0;
        next_pin_oe = 1'b1;
        if (t_done)
        begin
          next_dirty = 1'b0;
          next_do_save = 1'b0;
          next_state = ST_RESUME;
          t_load = 1'b1;
          t_count = CNT_W'(CYC_LZHSB); // R9
        end
      end
      ST_RESUME:
      begin
        // Interval restarts while the pin is still held low
        t_count = CNT_W'(CYC_LZHSB); // R9
        if (!busy_s)
          t_load = 1'b1;
        if (t_done)
          next_state = vcc_s ? ST_IDLE : ST_POWERUP; // R9
      end
      ST_SLEEP_ENTER:
      begin
        if (t_done)
          next_state = ST_SLEEP; // R6
      end
      ST_SLEEP:
      begin
        if (wake_s)
        begin
          next_state = ST_WAKE;
          t_load = 1'b1;
          t_count = CNT_W'(WAKE_CYC); // R7
        end
      end
      ST_WAKE:
      begin
        if (t_done)
          next_state = ST_IDLE; // R7
      end
    endcase
    if (sram_write && status.access_ok)
      next_dirty = 1'b1;
    // Standby counter runs after deselect
    next_sb_cnt = sb_cnt;
    next_standby = standby;
    if (!cs_s || next_state != ST_IDLE)
    begin
      next_sb_cnt = '0;
      next_standby = 1'b0;
    end
    else if (sb_cnt != CNT_W'(SB_CYC))
      next_sb_cnt = sb_cnt + 1'b1;
    else
      next_standby = 1'b1; // R8
    next_status.access_ok = vcc_s && (next_state == ST_IDLE); // R2 R4
    next_status.sram_en = (vcc_s && next_state == ST_IDLE) || next_state == ST_DELAY; // R3
    next_status.saving = (next_state == ST_SAVE);
    next_status.restoring = (next_state == ST_RESTORE);
    next_status.sleeping = (next_state == ST_SLEEP);
    next_status.standby = next_standby;
  end

  always_ff @(posedge clk_sys or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      state <= ST_POWERUP;
      pend <= CMD_NONE;
      dirty <= 1'b0;
      auto_en <= 1'b1;
      do_save <= 1'b0;
      vcc_prev <= 1'b0;
      busy_prev <= 1'b1;
      sb_cnt <= '0;
      standby <= 1'b0;
      xfer_save <= 1'b0;
      xfer_restore <= 1'b0;
      store_busy_pin_out <= 1'b1;
      store_busy_pin_oe <= 1'b0;
      status <= '0;
    end
    else
    begin
      state <= next_state;
      pend <= next_pend;
      dirty <= next_dirty;
      auto_en <= next_auto_en;
      do_save <= next_do_save;
      vcc_prev <= next_vcc_prev;
      busy_prev <= next_busy_prev;
      sb_cnt <= next_sb_cnt;
      standby <= next_standby;
      xfer_save <= next_xfer_save;
      xfer_restore <= next_xfer_restore;
      store_busy_pin_out <= next_pin_out;
      store_busy_pin_oe <= next_pin_oe;
      status <= next_status;
    end
  end
endmodule

// [nv_seq_monitor.sv]
// Port-level checker for the save/restore sequencer
module nv_seq_monitor
  import nv_seq_pkg::*;
#(
  parameter int STORE_CYC = 60,
  parameter int SS_CYC = 20,
  parameter int SLEEP_CYC = 50,
  parameter int WAKE_CYC = 40,
  parameter int SB_CYC = 30
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic vcc_ok,
  input wire logic cs_n,
  input wire logic wake_req,
  input wire logic store_busy_pin_in,
  input wire nv_seq_pkg::sw_req_t sw_req,
  input wire logic xfer_save,
  input wire logic xfer_restore,
  input wire nv_seq_pkg::seq_status_t status
);
  localparam int SV_MAX = STORE_CYC + 4;
  // Bound held under the range limit; the design acts within a few cycles
  localparam int SS_LIM = (SS_CYC > 1000) ? 1000 : SS_CYC;
  localparam int SL_MAX = SLEEP_CYC + 8;
  localparam int WK_MAX = WAKE_CYC + 8;
  // Busy may be released before the save it covers ends
  localparam int LZ_MAX = CYC_LZHSB + STORE_CYC + 16;
  int idle_cnt;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      idle_cnt <= 0;
    else if (cs_n && (status.access_ok || status.standby))
      idle_cnt <= idle_cnt + 1;
    else
      idle_cnt <= 0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_xfer_blocks_host:
    assert property ((status.saving || status.restoring) |-> !status.access_ok)
    else $error("access open in transfer");
  a_save_delay:
    assert property (xfer_save |-> $past(status.sram_en))
    else $error("save without write grace");
  a_save_len:
    assert property ($rose(status.saving) |-> ##[1:SV_MAX] !status.saving)
    else $error("save too long");
  a_sw_start:
    assert property ((cs_n [*3] ##0 (sw_req.valid && sw_req.cmd == CMD_RESTORE
      && status.access_ok)) |-> ##[1:SS_LIM] xfer_restore)
    else $error("restore not started");
  a_sleep_time:
    assert property ((cs_n [*3] ##0 (sw_req.valid && sw_req.cmd == CMD_SLEEP
      && status.access_ok)) |-> ##[1:SL_MAX] status.sleeping)
    else $error("sleep late");
  a_wake_time:
    assert property (($rose(wake_req) && status.sleeping) |-> ##[1:WK_MAX] status.access_ok)
    else $error("wake late");
  a_standby_time:
    assert property ((idle_cnt == SB_CYC + 4) |-> status.standby)
    else $error("standby late");
  a_resume_time:
    assert property (($rose(store_busy_pin_in) && vcc_ok && !status.sleeping
      && !status.restoring) |-> ##[1:LZ_MAX] status.access_ok)
    else $error("resume late");
endmodule

bind nv_store_recall_sequencer nv_seq_monitor #(.STORE_CYC(STORE_CYC), .SS_CYC(SS_CYC),
  .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .SB_CYC(SB_CYC)) mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .vcc_ok(vcc_ok), .cs_n(cs_n), .wake_req(wake_req),
  .store_busy_pin_in(store_busy_pin_in), .sw_req(sw_req), .xfer_save(xfer_save),
  .xfer_restore(xfer_restore), .status(status));

// [nv_host_model.sv]
// Host model issuing SRAM writes and software commands
module nv_host_model
  import nv_seq_pkg::*;
(
  // Clock and device status
  input wire logic clk_sys,
  input wire nv_seq_pkg::seq_status_t status,
  // Host requests
  output nv_seq_pkg::sw_req_t sw_req,
  output logic sram_write,
  output logic cs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sw_req = '0;
    sram_write = 1'b0;
    cs_n = 1'b1;
  end
  // Waits transfers out rather than leaning on the ignore path
  task automatic wait_ready(input int gap);
    for (int i = 0; i < 5000 && (status.access_ok | status.standby) !== 1'b1; i++)
      @(negedge clk_sys);
    repeat (gap) @(negedge clk_sys);
  endtask
  task automatic send(input sw_cmd_t cmd, input int gap);
    wait_ready(gap);
    sw_req <= {1'b1, cmd};
    @(negedge clk_sys);
    sw_req <= '0;
    // Idle is left only once the request is registered
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic write_burst(input int cnt);
    wait_ready(3);
    cs_n <= 1'b0;
    repeat (3) @(negedge clk_sys);
    repeat (cnt)
    begin
      sram_write <= 1'b1;
      @(negedge clk_sys);
      sram_write <= 1'b0;
      @(negedge clk_sys);
    end
    cs_n <= 1'b1;
  endtask
endmodule

// [nv_store_recall_sequencer_test.sv]
// Self-checking bench for the save/restore sequencer
module nv_store_recall_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import nv_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, vcc_ok, cs_n, wake_req, ext_low, sram_write, xfer_save, xfer_restore;
  logic store_busy_pin_in, store_busy_pin_out, store_busy_pin_oe;
  sw_req_t sw_req;
  seq_status_t status;
  logic [1:0] ev_q[$];
  logic [1:0] ev_exp;
  int failures = 0;
  int cmp_count = 0;
  int n;
  bit armed = 1'b0;
  sw_cmd_t cmds[5] = '{CMD_SAVE, CMD_RESTORE, CMD_AUTO_DIS, CMD_AUTO_EN, CMD_SLEEP};
  logic [1:0] exps[5] = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
  always #20 clk_sys = ~clk_sys;
  // Pulled up; either party may hold it low
  assign store_busy_pin_in =
    (ext_low || (store_busy_pin_oe && !store_busy_pin_out)) ? 1'b0 : 1'b1;
  nv_store_recall_sequencer #(.FA_CYC(40), .STORE_CYC(60), .RECALL_CYC(30),
    .SLEEP_CYC(50), .WAKE_CYC(40)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .vcc_ok(vcc_ok), .cs_n(cs_n), .wake_req(wake_req),
    .store_busy_pin_in(store_busy_pin_in), .store_busy_pin_out(store_busy_pin_out),
    .store_busy_pin_oe(store_busy_pin_oe), .sw_req(sw_req), .sram_write(sram_write),
    .xfer_save(xfer_save), .xfer_restore(xfer_restore), .status(status));
  nv_host_model host (.clk_sys(clk_sys), .status(status), .sw_req(sw_req),
    .sram_write(sram_write), .cs_n(cs_n));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_ok(output int cyc);
    for (cyc = 0; cyc < 5000 && status.access_ok !== 1'b1; cyc++)
      @(negedge clk_sys);
  endtask
  task automatic pin_save;
    host.wait_ready(3);
    ext_low = 1'b1;
    repeat (10) @(negedge clk_sys);
    ext_low = 1'b0;
    wait_ok(n);
    check("busy release", 8'(n < 320), 8'h01);
  endtask
  // Every transfer strobe once armed must match the oldest note
  always @(negedge clk_sys)
    if (armed && {xfer_save, xfer_restore} !== 2'b00)
    begin
      ev_exp = (ev_q.size() > 0) ? ev_q.pop_front() : 2'b00;
      check("transfer", {6'h00, xfer_save, xfer_restore}, {6'h00, ev_exp});
    end
  initial
  begin
    #800000;
    failures++;
    end_of_test();
  end
  initial
  begin
    rst_n = 1'b0;
    vcc_ok = 1'b1;
    wake_req = 1'b0;
    ext_low = 1'b0;
    n = $urandom(32'hD3B9);
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    wait_ok(n);
    check("power-up", 8'(n >= 40 && n < 190), 8'h01);
    armed = 1'b1;
    $display("test power_up done");
    pin_save();
    host.write_burst(1 + $urandom_range(0, 4));
    ev_q.push_back(2'b10);
    pin_save();
    $display("test pin_save done");
    foreach (cmds[i])
    begin
      if (exps[i] !== 2'b00)
        ev_q.push_back(exps[i]);
      host.send(cmds[i], $urandom_range(3, 9));
    end
    for (n = 0; n < 200 && status.sleeping !== 1'b1; n++) @(negedge clk_sys);
    check("sleep", 8'(status.sleeping), 8'h01);
    wake_req = 1'b1;
    wait_ok(n);
    wake_req = 1'b0;
    check("wake", 8'(n < 60), 8'h01);
    $display("test commands done");
    repeat (CYC_SB + 8) @(negedge clk_sys);
    check("standby", 8'(status.standby), 8'h01);
    $display("test standby done");
    host.write_burst(2 + $urandom_range(0, 3));
    ev_q.push_back(2'b10);
    vcc_ok = 1'b0;
    for (n = 0; n < 20 && status.saving !== 1'b1; n++) @(negedge clk_sys);
    for (n = 0; n < 200 && status.saving === 1'b1; n++) @(negedge clk_sys);
    check("save time", 8'(n > 0 && n <= 62), 8'h01);
    check("low supply", 8'(status.access_ok), 8'h00);
    repeat (5) @(negedge clk_sys);
    check("pending", 8'(ev_q.size()), 8'h00);
    $display("test power_loss done");
    end_of_test();
  end
endmodule
